// File: hw/program_space_access_unit.v
// Program space access unit: table access, visibility window, self-programming
//
// Overview of operation
// - Program counter steps two per word; low word and high byte share addresses.
// - Word-mode low table read returns program bits 15..0 unchanged.
// - Byte-mode low read returns upper byte if byte select 1, else lower.
// - Word-mode high read returns bits 23..16, upper data byte forced zero.
// - Byte-mode high read returns bits 23..16 for select 0, zero for select 1.
// - Table address is table page register above 16-bit effective address.
// - Table page bit 7 selects user space (0) or configuration space (1).
// - Data read goes to program memory when address bit 15 and enable set.
// - Window address is visibility page above effective address bits 14..0.
// - Window reads return only the low 16 bits; window is read-only.
// - Window access waits while a table read or write is in progress.
// - Outside repeat: moves cost one extra cycle, others two.
// - In repeat: first, last, interrupt exit and re-entry cost two extra.
// - Rows hold 64 words, pages eight rows, both aligned to their size.
// - Operations: erase one segment or page, program one row, or program one word.
// - 64-entry holding buffer loaded from one aligned group before start.
// - Table write only updates holding buffer and completes in two cycles.
// - Programming starts only through control register; one cycle per word.
// - Execution stalls from operation start until it finishes.
// - Write-start bit launches operation, hardware clears it, software cannot.
// - Sequence error flag set on any improper start attempt.
// - Erase 1101 segment, 0010 page; program 0011 word, 0001 row; others no-op.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "psa_consts.vh"

module program_space_access_unit #(
  parameter OP_CYCLES = `OP_CYCLES
) (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Table instruction request from the CPU
  input wire tbl_req,
  input wire tbl_write,
  input wire tbl_high,
  input wire tbl_byte,
  input wire [15:0] tbl_ea,
  input wire [15:0] tbl_wdata,
  output reg tbl_done,
  output reg [15:0] tbl_rdata,
  // Data-space read from the CPU
  input wire dread_req,
  input wire [15:0] dread_ea,
  output wire vis_hit,
  output wire vis_wait,
  output reg vis_done,
  output reg [15:0] vis_rdata,
  // Instruction context for the window penalty
  input wire instr_is_mov,
  input wire in_repeat,
  input wire rep_first,
  input wire rep_last,
  input wire rep_irq_exit,
  input wire rep_irq_reentry,
  output reg [1:0] vis_extra_cycles,
  // Program memory read port, data one cycle after pm_rd
  output reg pm_rd,
  output reg [23:0] pm_addr,
  output reg pm_cfg_space,
  input wire [23:0] pm_rdata,
  // Flash array command port
  output reg fl_erase_page,
  output reg fl_erase_seg,
  output reg fl_wr_en,
  output reg [23:0] fl_addr,
  output reg [23:0] fl_wr_data,
  // CPU stall
  output wire cpu_stall
);

  // ********************************************************
  // Access states
  // ********************************************************
  localparam S_IDLE = 3'd0;
  localparam S_TRD = 3'd1;
  localparam S_TCAP = 3'd2;
  localparam S_TWR = 3'd3;
  localparam S_PRD = 3'd4;
  localparam S_PCAP = 3'd5;

  localparam F_IDLE = 2'd0;
  localparam F_STREAM = 2'd1;
  localparam F_TIMER = 2'd2;

  localparam K_NONE = 2'd0;
  localparam K_FIRST = 2'd1;
  localparam K_OPEN = 2'd2;

  // ********************************************************
  // Storage
  // ********************************************************
  reg [2:0] acc_ff;
  reg [1:0] fsm_ff;
  reg [1:0] key_ff;
  reg wr_ff;
  reg wren_ff;
  reg err_ff;
  reg erase_ff;
  reg [3:0] op_ff;
  reg [7:0] tpag_ff;
  reg [7:0] vpag_ff;
  reg vis_en_ff;
  reg [23:0] last_addr_ff;
  reg [6:0] idx_ff;
  reg [15:0] timer_ff;
  reg cap_high_ff;
  reg cap_byte_ff;
  reg cap_bsel_ff;
  reg [23:0] hold_buf [0:`ROW_WORDS-1];

  wire apb_wr;
  wire apb_rd_setup;
  wire mapped;
  wire wr_attempt;
  wire op_valid;
  wire start_ok;
  wire tbl_take;
  wire vis_take;
  wire [23:0] tbl_addr;
  wire [5:0] wr_index;

  // Format a table read result from a program word
  function [15:0] fmt_read;
    input high;
    input bytem;
    input bsel;
    input [23:0] word;
    begin
      if (high) begin
        // Phantom byte reads as zero in both modes
        if (bytem && bsel)
          fmt_read = 16'h0000;
        else
          fmt_read = {8'h00, word[23:16]};
      end else if (bytem) begin
        fmt_read = bsel ? {8'h00, word[15:8]} : {8'h00, word[7:0]};
      end else begin
        fmt_read = word[15:0];
      end
    end
  endfunction

  // Merge a table write into a holding buffer entry
  function [23:0] merge_write;
    input high;
    input bytem;
    input bsel;
    input [23:0] old;
    input [15:0] wd;
    begin
      merge_write = old;
      if (high) begin
        if (!(bytem && bsel))
          merge_write[23:16] = wd[7:0];
      end else if (bytem) begin
        if (bsel)
          merge_write[15:8] = wd[7:0];
        else
          merge_write[7:0] = wd[7:0];
      end else begin
        merge_write[15:0] = wd;
      end
    end
  endfunction

  // ********************************************************
  // APB decode
  // ********************************************************
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd_setup = psel && !penable && !pwrite;
  assign mapped = (paddr == `OFF_FLASH_CTL) || (paddr == `OFF_UNLOCK_KEY) ||
                  (paddr == `OFF_TABLE_PAGE) || (paddr == `OFF_VIS_PAGE) ||
                  (paddr == `OFF_CORE_CTL);
  // Zero wait: read data is registered in setup, answered in access
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  assign op_valid = erase_ff_next_valid(pwdata[`CTL_ERASE_BIT], pwdata[3:0]);

  function erase_ff_next_valid;
    input er;
    input [3:0] op;
    begin
      if (er)
        erase_ff_next_valid = (op == `OP_SEG_ERASE) || (op == `OP_PAGE_ERASE);
      else
        erase_ff_next_valid = (op == `OP_WORD_PROG) || (op == `OP_ROW_PROG);
    end
  endfunction

  assign wr_attempt = apb_wr && (paddr == `OFF_FLASH_CTL) &&
                      pwdata[`CTL_WR_BIT];
  // start accepted only right after the unlock pair
  assign start_ok = wr_attempt && (key_ff == K_OPEN) && !wr_ff &&
                    pwdata[`CTL_WREN_BIT] && op_valid;

  // Read data sampled in the setup cycle; key reads as zero
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (apb_rd_setup) begin
      case (paddr)
        `OFF_FLASH_CTL: prdata <= {16'h0000, wr_ff, wren_ff, err_ff, 6'h00,
                                   erase_ff, 2'h0, op_ff};
        `OFF_TABLE_PAGE: prdata <= {24'h000000, tpag_ff};
        `OFF_VIS_PAGE: prdata <= {24'h000000, vpag_ff};
        `OFF_CORE_CTL: prdata <= {29'h00000000, vis_en_ff, 2'h0};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // ********************************************************
  // Control registers and unlock sequence
  // ********************************************************
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wren_ff <= 1'b0;
      err_ff <= 1'b0;
      erase_ff <= 1'b0;
      op_ff <= 4'h0;
      tpag_ff <= `PAGE_RST;
      vpag_ff <= `PAGE_RST;
      vis_en_ff <= 1'b0;
      key_ff <= K_NONE;
    end else begin
      if (apb_wr) begin
        // Any write other than the next key step breaks the sequence
        key_ff <= K_NONE;
        case (paddr)
          `OFF_FLASH_CTL: begin
            wren_ff <= pwdata[`CTL_WREN_BIT];
            erase_ff <= pwdata[`CTL_ERASE_BIT];
            op_ff <= pwdata[3:0];
            // flag: set on improper attempt, set beats clear
            if (wr_attempt && !start_ok)
              err_ff <= 1'b1;
            else
              err_ff <= pwdata[`CTL_ERR_BIT] & err_ff;
          end
          `OFF_UNLOCK_KEY: begin
            if (pwdata[7:0] == `KEY_FIRST)
              key_ff <= K_FIRST;
            else if (key_ff == K_FIRST && pwdata[7:0] == `KEY_SECOND)
              key_ff <= K_OPEN;
          end
          `OFF_TABLE_PAGE: tpag_ff <= pwdata[7:0];
          `OFF_VIS_PAGE: vpag_ff <= pwdata[7:0];
          `OFF_CORE_CTL: vis_en_ff <= pwdata[`CORE_VIS_BIT];
          default: ;
        endcase
      end
    end
  end

  // ********************************************************
  // Table and window access
  // ********************************************************
  // table address formed from page and effective address
  assign tbl_addr = {tpag_ff, tbl_ea};
  // two addresses per word, so the index skips bit 0
  assign wr_index = tbl_ea[6:1];
  // No take in the done cycle: a request still held there is the old one
  assign tbl_take = tbl_req && (acc_ff == S_IDLE) && !wr_ff && !tbl_done;
  // window hit needs address bit 15 and the enable bit
  assign vis_hit = dread_req && dread_ea[15] && vis_en_ff;
  // window waits behind any table access in progress
  assign vis_take = vis_hit && (acc_ff == S_IDLE) && !tbl_req && !wr_ff;
  assign vis_wait = vis_hit && !vis_take;

  // Access sequencer; table has priority over the window
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= S_IDLE;
      pm_rd <= 1'b0;
      pm_addr <= 24'h000000;
      pm_cfg_space <= 1'b0;
      tbl_done <= 1'b0;
      tbl_rdata <= 16'h0000;
      vis_done <= 1'b0;
      vis_rdata <= 16'h0000;
      cap_high_ff <= 1'b0;
      cap_byte_ff <= 1'b0;
      cap_bsel_ff <= 1'b0;
      last_addr_ff <= 24'h000000;
    end else begin
      tbl_done <= 1'b0;
      vis_done <= 1'b0;
      pm_rd <= 1'b0;
      case (acc_ff)
        S_IDLE: begin
          if (tbl_take) begin
            cap_high_ff <= tbl_high;
            cap_byte_ff <= tbl_byte;
            cap_bsel_ff <= tbl_ea[0];
            if (tbl_write) begin
              last_addr_ff <= tbl_addr;
              acc_ff <= S_TWR;
            end else begin
              pm_rd <= 1'b1;
              pm_addr <= tbl_addr;
              // page bit 7 picks configuration space
              pm_cfg_space <= tpag_ff[`TPAG_CFG_BIT];
              acc_ff <= S_TRD;
            end
          end else if (vis_take) begin
            pm_rd <= 1'b1;
            // window page above the low 15 address bits
            pm_addr <= {1'b0, vpag_ff, dread_ea[14:0]};
            pm_cfg_space <= 1'b0;
            acc_ff <= S_PRD;
          end
        end
        S_TRD: acc_ff <= S_TCAP;
        S_TCAP: begin
          tbl_rdata <= fmt_read(cap_high_ff, cap_byte_ff, cap_bsel_ff,
                                pm_rdata);
          tbl_done <= 1'b1;
          acc_ff <= S_IDLE;
        end
        S_TWR: begin
          // buffer write done in two cycles
          tbl_done <= 1'b1;
          acc_ff <= S_IDLE;
        end
        S_PRD: acc_ff <= S_PCAP;
        S_PCAP: begin
          // only the low word is visible
          vis_rdata <= pm_rdata[15:0];
          vis_done <= 1'b1;
          acc_ff <= S_IDLE;
        end
        default: acc_ff <= S_IDLE;
      endcase
    end
  end

  // holding buffer; the flash array is never touched here
  always @(posedge clock) begin
    if (tbl_take && tbl_write)
      hold_buf[wr_index] <= merge_write(tbl_high, tbl_byte, tbl_ea[0],
                                        hold_buf[wr_index], tbl_wdata);
  end

  // extra cycles for a window access
  always @* begin
    if (!in_repeat)
      vis_extra_cycles = instr_is_mov ? 2'd1 : 2'd2;
    else if (rep_first || rep_last || rep_irq_exit || rep_irq_reentry)
      vis_extra_cycles = 2'd2;
    else
      vis_extra_cycles = 2'd0;
  end

  // ********************************************************
  // Self-programming sequencer
  // ********************************************************
  // stall for the whole operation
  assign cpu_stall = wr_ff;

  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fsm_ff <= F_IDLE;
      wr_ff <= 1'b0;
      idx_ff <= 7'h00;
      timer_ff <= 16'h0000;
      fl_erase_page <= 1'b0;
      fl_erase_seg <= 1'b0;
      fl_wr_en <= 1'b0;
      fl_addr <= 24'h000000;
      fl_wr_data <= 24'h000000;
    end else begin
      fl_erase_page <= 1'b0;
      fl_erase_seg <= 1'b0;
      fl_wr_en <= 1'b0;
      case (fsm_ff)
        F_IDLE: begin
          // start only through the control register
          if (start_ok) begin
            wr_ff <= 1'b1;
            timer_ff <= 16'h0000;
            if (pwdata[`CTL_ERASE_BIT]) begin
              // page erase aligned to its page
              fl_erase_seg <= (pwdata[3:0] == `OP_SEG_ERASE);
              fl_erase_page <= (pwdata[3:0] == `OP_PAGE_ERASE);
              fl_addr <= last_addr_ff & `PAGE_MASK;
              fsm_ff <= F_TIMER;
            end else if (pwdata[3:0] == `OP_WORD_PROG) begin
              fl_wr_en <= 1'b1;
              fl_addr <= last_addr_ff;
              fl_wr_data <= hold_buf[last_addr_ff[6:1]];
              fsm_ff <= F_TIMER;
            end else begin
              idx_ff <= 7'h00;
              fsm_ff <= F_STREAM;
            end
          end
        end
        F_STREAM: begin
          // whole row from its aligned base
          fl_wr_en <= 1'b1;
          fl_addr <= (last_addr_ff & `ROW_MASK) | {16'h0000, idx_ff, 1'b0};
          fl_wr_data <= hold_buf[idx_ff[5:0]];
          idx_ff <= idx_ff + 7'h01;
          if (idx_ff == `ROW_WORDS - 1)
            fsm_ff <= F_TIMER;
        end
        F_TIMER: begin
          timer_ff <= timer_ff + 16'h0001;
          if (timer_ff == OP_CYCLES[15:0] - 16'h0001) begin
            wr_ff <= 1'b0;
            fsm_ff <= F_IDLE;
          end
        end
        default: fsm_ff <= F_IDLE;
      endcase
    end
  end

endmodule

// File: hw/psa_consts.vh
// Constants for the program space access unit
`ifndef PSA_CONSTS_VH
`define PSA_CONSTS_VH

// ********************************************************
// Register byte offsets on the APB
// ********************************************************
`define OFF_FLASH_CTL 8'h00
`define OFF_UNLOCK_KEY 8'h04
`define OFF_TABLE_PAGE 8'h08
`define OFF_VIS_PAGE 8'h0c
`define OFF_CORE_CTL 8'h10

// ********************************************************
// Field positions
// ********************************************************
`define CTL_WR_BIT 15
`define CTL_WREN_BIT 14
`define CTL_ERR_BIT 13
`define CTL_ERASE_BIT 6
`define CORE_VIS_BIT 2
`define TPAG_CFG_BIT 7

// ********************************************************
// Unlock key values and operation codes
// ********************************************************
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
`define OP_SEG_ERASE 4'hd
`define OP_PAGE_ERASE 4'h2
`define OP_WORD_PROG 4'h3
`define OP_ROW_PROG 4'h1

// ********************************************************
// Reset values, geometry and timing
// ********************************************************
`define CTL_RST 16'h0000
`define PAGE_RST 8'h00
`define CORE_RST 16'h0000
`define ROW_WORDS 64
`define ROW_MASK 24'hffff80
`define PAGE_MASK 24'hfffc00
`define OP_CYCLES 16'h0040

`endif

// File: verification/pm_model.sv
// Program memory model answering the unit's read port
`timescale 1ns/10ps
module pm_model (
  // Clock
  input wire clock,
  // Read request
  input wire pm_rd,
  input wire [23:0] pm_addr,
  input wire pm_cfg_space,
  // Read data
  output logic [23:0] pm_rdata
);
  function automatic logic [23:0] pat(input logic [23:0] a, input logic c);
    pat = {a[23:16] ^ {1'b0, c, 6'h07}, {a[15:1], 1'b0} ^ 16'h5a93};
  endfunction
  // data one cycle after request
  // Inverted otherwise, so a sample one cycle late never finds stale data
  initial pm_rdata = 24'h0;
  always @(posedge clock) begin
    if (pm_rd) begin
      pm_rdata <= pat(pm_addr, pm_cfg_space);
    end else begin
      pm_rdata <= ~pm_rdata;
    end
  end
endmodule

// File: verification/program_space_access_unit_tb_top.sv
// Testbench for the program space access unit
`timescale 1ns/10ps
`include "psa_consts.vh"
module program_space_access_unit_tb_top;
  logic clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic tbl_req = 0, tbl_write = 0, tbl_high = 0, tbl_byte = 0, e;
  logic [15:0] tbl_ea = 0, tbl_wdata = 0, dread_ea = 0, r, x;
  logic dread_req = 0, instr_is_mov = 0, in_repeat = 0, rep_first = 0;
  logic rep_last = 0, rep_irq_exit = 0, rep_irq_reentry = 0;
  wire [31:0] prdata;
  wire [15:0] tbl_rdata, vis_rdata;
  wire [23:0] pm_addr, pm_rdata, fl_addr, fl_wr_data;
  wire [1:0] vis_extra_cycles;
  wire pready, pslverr, tbl_done, vis_hit, vis_wait, vis_done, pm_rd;
  wire pm_cfg_space, fl_erase_page, fl_erase_seg, fl_wr_en, cpu_stall;
  int err_total = 0, checks_done = 0, n_wr, n_pe, n_se;
  logic [23:0] a_first, d_first, w;

  // Short self-timed length keeps the run brief
  program_space_access_unit #(.OP_CYCLES(4)) i_program_space_access_unit (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tbl_req, .tbl_write, .tbl_high, .tbl_byte, .tbl_ea,
    .tbl_wdata, .tbl_done, .tbl_rdata, .dread_req, .dread_ea, .vis_hit,
    .vis_wait, .vis_done, .vis_rdata, .instr_is_mov, .in_repeat, .rep_first,
    .rep_last, .rep_irq_exit, .rep_irq_reentry, .vis_extra_cycles, .pm_rd,
    .pm_addr, .pm_cfg_space, .pm_rdata, .fl_erase_page, .fl_erase_seg,
    .fl_wr_en, .fl_addr, .fl_wr_data, .cpu_stall);
  pm_model i_pm_model (.clock, .pm_rd, .pm_addr, .pm_cfg_space, .pm_rdata);

  // Clock and flash command tally
  always #25 clock = ~clock;
  always @(posedge clock) begin
    if (fl_wr_en && n_wr == 0) begin
      a_first = fl_addr;
      d_first = fl_wr_data;
    end
    n_wr += fl_wr_en;
    n_pe += fl_erase_page;
    n_se += fl_erase_seg;
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  function automatic logic [23:0] pat(input logic [23:0] a, input logic c);
    pat = {a[23:16] ^ {1'b0, c, 6'h07}, {a[15:1], 1'b0} ^ 16'h5a93};
  endfunction
  task give_verdict;
    $display("mismatches %0d, checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait; running out ends the run
  task automatic wait_for(input int lim, ref logic flag, input logic lvl);
    int n;
    n = 0;
    do begin @(posedge clock); n++; end while (flag !== lvl && n < lim);
    if (flag !== lvl) begin err_total++; give_verdict; end
  endtask
  logic rdy, done_t, done_v, go_v, stall_n;
  always @* rdy = pready;
  always @* done_t = tbl_done;
  always @* done_v = vis_done;
  always @* go_v = vis_hit && !vis_wait;
  always @* stall_n = !cpu_stall;
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    wait_for(20, rdy, 1);
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task tbl(input logic wr, h, b, input logic [15:0] ea, wd);
    @(posedge clock);
    tbl_req <= 1; tbl_write <= wr; tbl_high <= h; tbl_byte <= b;
    tbl_ea <= ea; tbl_wdata <= wd;
    wait_for(20, done_t, 1);
    r = tbl_rdata;
    tbl_req <= 0;
  endtask
  task win(input logic [15:0] ea);
    @(posedge clock);
    dread_req <= 1; dread_ea <= ea;
    wait_for(40, go_v, 1);
    dread_req <= 0;
    wait_for(20, done_v, 1);
    x = vis_rdata;
  endtask

  // ********************************************************
  // Scenarios
  // ********************************************************
  task t_regs;
    for (int i = 0; i < 6; i++) begin
      apb(0, 8'(4 * i), 0);
      chk({e, q}, {i == 5, 32'h0});
    end
    apb(1, `OFF_TABLE_PAGE, 32'hffffffab);
    apb(0, `OFF_TABLE_PAGE, 0);
    chk(q, 32'hab);
    apb(1, `OFF_CORE_CTL, 32'hffff);
    apb(0, `OFF_CORE_CTL, 0);
    chk(q, 32'h4);
  endtask
  task t_tread;
    for (int i = 0; i < 16; i++) begin
      logic [7:0] pg;
      logic [15:0] ea, ex;
      pg = i[3] ? 8'h83 : 8'h05;
      ea = 16'h2468 | 16'(i[0]);
      apb(1, `OFF_TABLE_PAGE, {24'h0, pg});
      tbl(0, i[2], i[1], ea, 0);
      w = pat({pg, ea}, pg[7]);
      case (i[2:1])
        2'h0: ex = w[15:0];
        2'h1: ex = {8'h0, ea[0] ? w[15:8] : w[7:0]};
        2'h2: ex = {8'h0, w[23:16]};
        default: ex = ea[0] ? 16'h0 : {8'h0, w[23:16]};
      endcase
      chk(r, ex);
    end
  endtask
  task t_window;
    apb(1, `OFF_CORE_CTL, 0);
    @(posedge clock);
    dread_req <= 1; dread_ea <= 16'h8000;
    @(posedge clock);
    @(posedge clock);
    chk(vis_hit, 0);
    dread_req <= 0;
    apb(1, `OFF_VIS_PAGE, 32'h12);
    apb(1, `OFF_CORE_CTL, 32'h4);
    win(16'h9abd);
    chk(x, pat({1'b0, 8'h12, 15'h1abd}, 0) & 24'hffff);
    // Table and window race: window must wait its turn
    fork
      tbl(0, 1, 0, 16'h0010, 0);
      win(16'hc002);
    join
    chk({r, x}, {8'h0, 8'(pat(24'h830010, 1) >> 16),
      16'(pat(24'h094002, 0))});
    for (int i = 0; i < 64; i++) begin
      @(posedge clock);
      {instr_is_mov, in_repeat, rep_first, rep_last, rep_irq_exit,
        rep_irq_reentry} <= i[5:0];
      @(posedge clock);
      chk(vis_extra_cycles, !i[4] ? (i[5] ? 1 : 2) : (|i[3:0] ? 2 : 0));
    end
  endtask
  task op(input logic k, er, input logic [3:0] c, input logic ok);
    logic [15:0] v;
    v = {2'b01, 7'h0, er, 2'b00, c};
    n_wr = 0; n_pe = 0; n_se = 0;
    if (k) apb(1, `OFF_UNLOCK_KEY, `KEY_FIRST);
    if (k) apb(1, `OFF_UNLOCK_KEY, `KEY_SECOND);
    apb(1, `OFF_FLASH_CTL, {16'h0, v | 16'h8000});
    @(posedge clock);
    chk(cpu_stall, ok);
    wait_for(400, stall_n, 1);
    apb(0, `OFF_FLASH_CTL, 0);
    chk(q, ok ? v : v | 16'h2000);
    apb(1, `OFF_FLASH_CTL, {16'h0, v});
  endtask
  task t_flash;
    apb(1, `OFF_TABLE_PAGE, 0);
    tbl(1, 0, 0, 16'h0100, 16'hbeef);
    tbl(1, 1, 0, 16'h0100, 16'h00c3);
    tbl(1, 0, 0, 16'h017e, 16'h1357);
    tbl(1, 1, 0, 16'h017e, 16'h0024);
    chk(n_wr, 0);
    op(1, 0, `OP_ROW_PROG, 1);
    chk({n_wr, a_first, d_first}, {32'd64, 48'h000100c3beef});
    op(1, 0, `OP_WORD_PROG, 1);
    chk({n_wr, a_first, d_first}, {32'd1, 48'h00017e241357});
    op(1, 1, `OP_PAGE_ERASE, 1);
    chk({n_pe, n_se, n_wr}, {32'd1, 32'd0, 32'd0});
    op(1, 1, `OP_SEG_ERASE, 1);
    chk({n_pe, n_se}, {32'd0, 32'd1});
    op(0, 0, `OP_WORD_PROG, 0);
    op(1, 1, `OP_WORD_PROG, 0);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rstn <= 1;
    t_regs;
    t_tread;
    t_window;
    t_flash;
    give_verdict;
  end
endmodule

// File: verification/psa_checker.sv
// Port checker for the program space access unit
`timescale 1ns/10ps
`include "psa_consts.vh"
module psa_checker (
  // Clock and reset
  input wire clock,
  input wire rstn,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  // Table and window requests
  input wire tbl_req,
  input wire tbl_done,
  input wire dread_req,
  input wire [15:0] dread_ea,
  input wire vis_hit,
  input wire vis_wait,
  input wire vis_done,
  // Penalty context
  input wire instr_is_mov,
  input wire in_repeat,
  input wire rep_first,
  input wire rep_last,
  input wire rep_irq_exit,
  input wire rep_irq_reentry,
  input wire [1:0] vis_extra_cycles,
  // Memory and flash ports
  input wire pm_rd,
  input wire [23:0] pm_addr,
  input wire pm_cfg_space,
  input wire fl_erase_page,
  input wire fl_erase_seg,
  input wire fl_wr_en,
  input wire [23:0] fl_addr,
  input wire cpu_stall
);
  // ********************************************************
  // Properties
  // ********************************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_start;
    $rose(cpu_stall) |->
      $past(psel && penable && pwrite && paddr == `OFF_FLASH_CTL);
  endproperty
  a_start: assert property (p_start)
    else $error("stall rose without a control write");
  property p_stall; cpu_stall [*2] |-> !pm_rd; endproperty
  a_stall: assert property (p_stall)
    else $error("memory read while stalled");
  property p_fl_busy;
    fl_wr_en || fl_erase_page || fl_erase_seg |-> cpu_stall;
  endproperty
  a_fl_busy: assert property (p_fl_busy)
    else $error("flash touched outside an operation");
  property p_one_op;
    fl_erase_page || fl_erase_seg |->
      !fl_wr_en && !(fl_erase_page && fl_erase_seg);
  endproperty
  a_one_op: assert property (p_one_op)
    else $error("two flash commands at once");
  property p_page_al; fl_erase_page |-> fl_addr[9:0] == 10'h000; endproperty
  a_page_al: assert property (p_page_al)
    else $error("page erase address not aligned");
  property p_even; fl_wr_en |-> !fl_addr[0]; endproperty
  a_even: assert property (p_even)
    else $error("word program at odd address");
  property p_hit; vis_hit |-> dread_req && dread_ea[15]; endproperty
  a_hit: assert property (p_hit)
    else $error("window hit without upper half read");
  property p_vis;
    vis_hit && !vis_wait && !tbl_req && !cpu_stall |=>
      pm_rd && !pm_cfg_space && !pm_addr[23] &&
      pm_addr[14:0] == $past(dread_ea[14:0]) ##2 vis_done;
  endproperty
  a_vis: assert property (p_vis)
    else $error("window read address or timing wrong");
  property p_xout;
    !in_repeat |-> vis_extra_cycles == (instr_is_mov ? 2'h1 : 2'h2);
  endproperty
  a_xout: assert property (p_xout)
    else $error("penalty outside repeat wrong");
  property p_xin;
    in_repeat |-> vis_extra_cycles == ((rep_first || rep_last ||
      rep_irq_exit || rep_irq_reentry) ? 2'h2 : 2'h0);
  endproperty
  a_xin: assert property (p_xin)
    else $error("penalty inside repeat wrong");
  property p_done; tbl_done |=> !tbl_done; endproperty
  a_done: assert property (p_done)
    else $error("table done longer than one cycle");
  // Main scenarios reached
  c_row: cover property (fl_wr_en);
  c_erase: cover property (fl_erase_page);
  c_win: cover property (vis_done);
endmodule

bind program_space_access_unit psa_checker i_psa_checker (.clock, .rstn,
  .psel, .penable, .pwrite, .paddr, .tbl_req, .tbl_done, .dread_req,
  .dread_ea, .vis_hit, .vis_wait, .vis_done, .instr_is_mov, .in_repeat,
  .rep_first, .rep_last, .rep_irq_exit, .rep_irq_reentry,
  .vis_extra_cycles, .pm_rd, .pm_addr, .pm_cfg_space, .fl_erase_page,
  .fl_erase_seg, .fl_wr_en, .fl_addr, .cpu_stall);
